// *** rtl/postsq_pkg.sv ***
/*
 Power-on self-test sequencer package: phase timing, display codes,
 indicator widths and the carrier structs of the sequencer ports.
 Assumes a 100 MHz clock; long counts are overridable in the top module.
*/
package postsq_pkg;

    localparam int CLK_MHZ = 100;
    localparam int LAMP_MS = 500;
    localparam int VERSION_MS = 3000;
    localparam int COMPLETE_MS = 1000;
    localparam int TEST_US = 100;
    localparam int LAMP_CYC = LAMP_MS * 1000 * CLK_MHZ;
    localparam int VERSION_CYC = VERSION_MS * 1000 * CLK_MHZ;
    localparam int COMPLETE_CYC = COMPLETE_MS * 1000 * CLK_MHZ;
    localparam int TEST_CYC = TEST_US * CLK_MHZ;

    localparam int NUM_TESTS = 8;
    localparam int NUM_IND = 16;
    localparam int NUM_BTN = 16;
    localparam int CNT_W = 32;
    localparam int IDX_W = 3;

    // Readout message codes shown on the mainframe screen
    localparam logic [1:0] MSG_NONE = 2'h0;
    localparam logic [1:0] MSG_BUSY = 2'h1;
    localparam logic [1:0] MSG_COMPLETE = 2'h2;
    localparam logic [1:0] MSG_FAIL = 2'h3;

    // Four digits, each a 4-bit value plus decimal point
    localparam logic [15:0] DIGITS_ALL_EIGHT = 16'h8888;
    localparam logic [3:0] DP_ALL = 4'hf;
    localparam logic [3:0] DP_NONE = 4'h0;
    // Arbitrary firmware version value
    localparam logic [15:0] FW_VERSION = 16'h0100;
    localparam logic [NUM_BTN-1:0] LAMP_SUBSET = 16'h00ff;

    typedef struct packed {
        logic [1:0] msg;
        logic [7:0] code;
    } postsq_readout_s;

    typedef struct packed {
        logic [15:0] digits;
        logic [3:0] dp;
        logic blank_n;
    } postsq_numeric_s;

    typedef struct packed {
        logic [NUM_TESTS-1:0] red;
        logic [NUM_TESTS-1:0] green;
    } postsq_func_led_s;

    typedef enum logic [2:0] {
        ST_LAMP, ST_TEST, ST_HALT, ST_VERSION, ST_COMPLETE, ST_NORMAL
    } postsq_state_e;

endpackage

// *** rtl/postsq_sequencer.sv ***
/*
 Power-on self-test sequencer: lamp and segment check, test stepping
 with halt on failure, firmware version display, completion message.
 Assumes test engines outside report pass/fail per test index on a
 done strobe from the same clock; pushbuttons are asynchronous pins.
*/
// How it works
// - Sequence starts by itself after reset release
// - Busy message shown while sequence runs
// - Complete message shown briefly, then removed
// - All indicators and some button lamps lit
// - Numeric display shows 8.8.8.8. first
// - Version shown few seconds if no failure
// - Failure reported on screen, digits, LEDs
// - Each test LED red failed, green passed
// - Halt and hold indications on failure
// - Screen and digits show failing test code
// - Any pushbutton press resumes remaining tests
`timescale 1ns/10ps
module postsq_sequencer
    import postsq_pkg::*;
#(
    parameter int LAMP_CYCLES = LAMP_CYC,
    parameter int VERSION_CYCLES = VERSION_CYC,
    parameter int COMPLETE_CYCLES = COMPLETE_CYC
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [NUM_BTN-1:0] button_in,
    input wire logic test_done,
    input wire logic test_fail,
    output postsq_readout_s readout,
    output postsq_numeric_s numeric,
    output postsq_func_led_s func_led,
    output logic [NUM_IND-1:0] indicator,
    output logic [NUM_BTN-1:0] button_lamp,
    output logic test_start,
    output logic [IDX_W-1:0] test_index,
    output logic normal_mode
);

    postsq_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic any_fail_q, any_fail_d;
    logic start_q, start_d;
    logic [NUM_TESTS-1:0] red_q, red_d, green_q, green_d;
    postsq_readout_s ro_q, ro_d;
    postsq_numeric_s num_q, num_d;
    logic [NUM_IND-1:0] ind_q, ind_d;
    logic [NUM_BTN-1:0] lamp_q, lamp_d;
    logic normal_q, normal_d;

    // Three-stage button synchroniser; s1 is read only by s2
    logic [NUM_BTN-1:0] s1_q, s2_q, s3_q, btn_q, btn_d;
    logic press;

    always_comb
    begin
        btn_d = btn_q;
        for (int i = 0; i < NUM_BTN; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                btn_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            btn_q <= '0;
        end
        else
        begin
            s1_q <= button_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            btn_q <= btn_d;
        end
    end

    // Rising edge of any debounced button
    assign press = |(btn_d & ~btn_q);

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q + 32'h1;
        idx_d = idx_q;
        any_fail_d = any_fail_q;
        start_d = 1'b0;
        red_d = red_q;
        green_d = green_q;
        ro_d = ro_q;
        num_d = num_q;
        ind_d = ind_q;
        lamp_d = lamp_q;
        normal_d = normal_q;
        case (state_q)
            ST_LAMP:
            begin
                ro_d = '{msg: MSG_BUSY, code: 8'h00};
                num_d = '{digits: DIGITS_ALL_EIGHT, dp: DP_ALL,
                          blank_n: 1'b1};
                ind_d = '1;
                lamp_d = LAMP_SUBSET;
                if (cnt_q >= CNT_W'(LAMP_CYCLES - 1))
                begin
                    state_d = ST_TEST;
                    cnt_d = '0;
                    ind_d = '0;
                    lamp_d = '0;
                    start_d = 1'b1;
                    num_d.blank_n = 1'b0;
                end
            end
            ST_TEST:
            begin
                if (test_done)
                begin
                    cnt_d = '0;
                    if (test_fail)
                    begin
                        // Same code on both paths, screen and digits
                        red_d[idx_q] = 1'b1;
                        any_fail_d = 1'b1;
                        ro_d = '{msg: MSG_FAIL,
                                 code: {5'h00, idx_q} + 8'h01};
                        num_d = '{digits: {13'h0000, idx_q} + 16'h0001,
                                  dp: DP_NONE, blank_n: 1'b1};
                        state_d = ST_HALT;
                    end
                    else
                    begin
                        green_d[idx_q] = 1'b1;
                        if (idx_q == IDX_W'(NUM_TESTS - 1))
                        begin
                            state_d = any_fail_q ? ST_COMPLETE
                                                 : ST_VERSION;
                            num_d = '{digits: FW_VERSION, dp: DP_NONE,
                                      blank_n: !any_fail_q};
                            if (any_fail_q)
                            begin
                                ro_d.msg = MSG_COMPLETE;
                            end
                        end
                        else
                        begin
                            idx_d = idx_q + 3'h1;
                            start_d = 1'b1;
                        end
                    end
                end
            end
            ST_HALT:
            begin
                // Indications held until an operator press
                if (press)
                begin
                    ro_d = '{msg: MSG_BUSY, code: 8'h00};
                    num_d.blank_n = 1'b0;
                    if (idx_q == IDX_W'(NUM_TESTS - 1))
                    begin
                        state_d = ST_COMPLETE;
                        ro_d.msg = MSG_COMPLETE;
                    end
                    else
                    begin
                        state_d = ST_TEST;
                        idx_d = idx_q + 3'h1;
                        start_d = 1'b1;
                    end
                    cnt_d = '0;
                end
            end
            ST_VERSION:
            begin
                if (cnt_q >= CNT_W'(VERSION_CYCLES - 1))
                begin
                    state_d = ST_COMPLETE;
                    cnt_d = '0;
                    num_d.blank_n = 1'b0;
                    ro_d.msg = MSG_COMPLETE;
                end
            end
            ST_COMPLETE:
            begin
                if (cnt_q >= CNT_W'(COMPLETE_CYCLES - 1))
                begin
                    state_d = ST_NORMAL;
                    ro_d = '{msg: MSG_NONE, code: 8'h00};
                    red_d = '0;
                    green_d = '0;
                    normal_d = 1'b1;
                end
            end
            ST_NORMAL:
            begin
                cnt_d = cnt_q;
            end
            default:
            begin
                state_d = ST_NORMAL;
            end
        endcase
    end

    // Reset release begins the lamp phase with no operator action
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_LAMP;
            cnt_q <= '0;
            idx_q <= '0;
            any_fail_q <= 1'b0;
            start_q <= 1'b0;
            red_q <= '0;
            green_q <= '0;
            ro_q <= '{msg: MSG_BUSY, code: 8'h00};
            num_q <= '0;
            ind_q <= '0;
            lamp_q <= '0;
            normal_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            any_fail_q <= any_fail_d;
            start_q <= start_d;
            red_q <= red_d;
            green_q <= green_d;
            ro_q <= ro_d;
            num_q <= num_d;
            ind_q <= ind_d;
            lamp_q <= lamp_d;
            normal_q <= normal_d;
        end
    end

    assign readout = ro_q;
    assign numeric = num_q;
    assign func_led = '{red: red_q, green: green_q};
    assign indicator = ind_q;
    assign button_lamp = lamp_q;
    assign test_start = start_q;
    assign test_index = idx_q;
    assign normal_mode = normal_q;

    a_busy_msg: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == ST_TEST) |-> ro_q.msg == MSG_BUSY)
        else $error("busy message missing during test");
    a_halt_hold: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == ST_HALT && !press) |=> state_q == ST_HALT)
        else $error("halt left without press");
    a_fail_red: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == ST_TEST && test_done && test_fail)
        |=> red_q[$past(idx_q)] && ro_q.msg == MSG_FAIL)
        else $error("failure not shown red");
    a_code_match: assert property (@(posedge clock)
        disable iff (!nrst)
        (state_q == ST_HALT) |-> ro_q.code[3:0] == num_q.digits[3:0])
        else $error("screen and digit codes differ");
    a_resume_press: assert property (@(posedge clock)
        disable iff (!nrst)
        (state_q == ST_HALT && press && idx_q != 3'h7)
        |=> state_q == ST_TEST && test_start)
        else $error("press did not resume tests");
    a_seg_check: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == ST_LAMP && cnt_q > 32'h0)
        |-> num_q.digits == DIGITS_ALL_EIGHT && &ind_q)
        else $error("segment check not lit");
    a_complete_msg: assert property (@(posedge clock)
        disable iff (!nrst)
        $rose(normal_q) |-> ro_q.msg == MSG_NONE && red_q == '0)
        else $error("displays not released");
    a_version_ok: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == ST_VERSION) |-> !any_fail_q && num_q.blank_n)
        else $error("version shown after failure");

endmodule

// *** testbench/postsq_partner.sv ***
/*
 Test engine model: answers each test_start with a one-cycle test_done
 after a set latency, failing the tests marked in fail_mask.
 Assumes the sequencer clock and reset.
*/
`timescale 1ns/10ps
module postsq_partner
    import postsq_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic test_start,
    input wire logic [IDX_W-1:0] test_index,
    input wire logic [NUM_TESTS-1:0] fail_mask,
    input wire logic [3:0] latency,
    output logic test_done,
    output logic test_fail
);
    logic busy_q;
    logic [3:0] cnt_q;
    logic [IDX_W-1:0] idx_q;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            idx_q <= '0;
            test_done <= 1'b0;
            test_fail <= 1'b0;
        end
        else
        begin
            test_done <= 1'b0;
            // Outside a result the qualifier toggles, so it is never trusted
            test_fail <= ~test_fail;
            if (test_start)
            begin
                busy_q <= 1'b1;
                cnt_q <= latency;
                idx_q <= test_index;
            end
            else if (busy_q && cnt_q == 4'h0)
            begin
                busy_q <= 1'b0;
                test_done <= 1'b1;
                test_fail <= fail_mask[idx_q];
            end
            else if (busy_q)
                cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule

// *** testbench/power_on_self_test_sequencer_bench.sv ***
/*
 Self-checking bench: clean run, mid-sequence halt, halt on the last test.
 Assumes shortened phase counts of 10, 20 and 10 cycles.
*/
`timescale 1ns/10ps
module power_on_self_test_sequencer_bench;
    import postsq_pkg::*;
    localparam int LAMP_N = 10;
    localparam int VER_N = 20;
    localparam int CMP_N = 10;
    logic clock;
    logic nrst;
    logic [NUM_BTN-1:0] button_in;
    logic test_done;
    logic test_fail;
    postsq_readout_s readout;
    postsq_numeric_s numeric;
    postsq_func_led_s func_led;
    logic [NUM_IND-1:0] indicator;
    logic [NUM_BTN-1:0] button_lamp;
    logic test_start;
    logic [IDX_W-1:0] test_index;
    logic normal_mode;
    logic [NUM_TESTS-1:0] fail_mask;
    logic [3:0] latency;
    int fails;
    int checks;
    int ver_cyc;
    int cmp_cyc;
    postsq_func_led_s led_at_cmp;

    postsq_sequencer #(.LAMP_CYCLES(LAMP_N), .VERSION_CYCLES(VER_N),
        .COMPLETE_CYCLES(CMP_N)) dut (.clock(clock), .nrst(nrst),
        .button_in(button_in), .test_done(test_done),
        .test_fail(test_fail), .readout(readout), .numeric(numeric),
        .func_led(func_led), .indicator(indicator),
        .button_lamp(button_lamp), .test_start(test_start),
        .test_index(test_index), .normal_mode(normal_mode));

    postsq_partner engine (.clock(clock), .nrst(nrst),
        .test_start(test_start), .test_index(test_index),
        .fail_mask(fail_mask), .latency(latency),
        .test_done(test_done), .test_fail(test_fail));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check(readout.msg, MSG_BUSY);
        nrst = 1'b1;
    endtask

    // Runs until normal mode, counting version and complete spans
    task automatic run_to_normal();
        ver_cyc = 0;
        cmp_cyc = 0;
        for (int i = 0; i < 2000; i++)
        begin
            @(posedge clock);
            #1;
            if (normal_mode === 1'b1)
                return;
            if (numeric.digits === FW_VERSION && numeric.blank_n === 1'b1)
                ver_cyc++;
            if (readout.msg === MSG_COMPLETE)
            begin
                cmp_cyc++;
                led_at_cmp = func_led;
            end
            else
                check(readout.msg, MSG_BUSY);
        end
        fails++;
        close_out();
    endtask

    // Bounded wait for the failure indications
    task automatic wait_fail();
        for (int i = 0; i < 500; i++)
        begin
            @(posedge clock);
            #1;
            if (readout.msg === MSG_FAIL)
                return;
        end
        fails++;
        close_out();
    endtask

    // Held long enough for the three-stage synchroniser to agree
    task automatic press_button(input logic [NUM_BTN-1:0] which);
        @(posedge clock);
        #1;
        button_in = which;
        repeat (6) @(posedge clock);
        #1;
        button_in = '0;
    endtask

    task automatic clean_run();
        fail_mask = 8'h00;
        latency = 4'h0;
        do_reset();
        @(posedge clock);
        #1;
        check(numeric.digits, DIGITS_ALL_EIGHT);
        check(numeric.dp, DP_ALL);
        check(indicator, 16'hffff);
        check(button_lamp, LAMP_SUBSET);
        run_to_normal();
        check(ver_cyc, VER_N);
        check(cmp_cyc, CMP_N);
        check(led_at_cmp, 16'h00ff);
        check(readout.msg, MSG_NONE);
        check(func_led, 16'h0000);
        check(indicator, 16'h0000);
        check(button_lamp, 16'h0000);
    endtask

    task automatic halt_run();
        int starts;
        fail_mask = 8'h04;
        latency = 4'h5;
        do_reset();
        wait_fail();
        check(readout.msg, MSG_FAIL);
        check(readout.code, 8'h03);
        check(numeric.digits, 16'h0003);
        check(numeric.blank_n, 1'b1);
        check(func_led, 16'h0403);
        starts = 0;
        repeat (30)
        begin
            @(posedge clock);
            #1;
            starts += test_start;
        end
        check(starts, 0);
        check(readout.msg, MSG_FAIL);
        check(test_index, 3'h2);
        press_button(16'h0020);
        run_to_normal();
        check(ver_cyc, 0);
        check(cmp_cyc, CMP_N);
        check(led_at_cmp, 16'h04fb);
        check(normal_mode, 1'b1);
    endtask

    // Failure on the last test: a press goes straight to completion
    task automatic last_fail_run();
        fail_mask = 8'h80;
        latency = 4'h0;
        do_reset();
        wait_fail();
        check(readout.code, 8'h08);
        check(numeric.digits, 16'h0008);
        check(func_led, 16'h807f);
        // Held until normal mode; only its first edge may count
        button_in = 16'h8000;
        for (int i = 0; i < 8 && readout.msg === MSG_FAIL; i++)
        begin
            @(posedge clock);
            #1;
        end
        if (readout.msg === MSG_FAIL)
        begin
            fails++;
            close_out();
        end
        check(readout.msg, MSG_COMPLETE);
        run_to_normal();
        button_in = '0;
        check(cmp_cyc, CMP_N - 1);
        check(ver_cyc, 0);
        check(led_at_cmp, 16'h807f);
        check(readout.msg, MSG_NONE);
    endtask

    initial
    begin
        fails = 0;
        checks = 0;
        nrst = 1'b0;
        button_in = '0;
        fail_mask = '0;
        latency = '0;
        clean_run();
        halt_run();
        last_fail_run();
        close_out();
    end
endmodule
